//--- hw/psc_pkg.sv
package psc_pkg;
   // Pad counts
   localparam int NUM_DIG  = 23;
   localparam int NUM_MIX  = 4;
   // Device power states
   typedef enum logic [2:0] {
      PSC_CORE_OFF,
      PSC_POR,
      PSC_DEFAULT,
      PSC_PROC_ACTIVE,
      PSC_RADIO_ACTIVE,
      PSC_DEEP_SLEEP
   } psc_state_t;
   // Reset values of firmware pad settings
   localparam logic RST_OE       = 1'b0;
   localparam logic RST_LEVEL    = 1'b0;
   localparam logic RST_PULL_EN  = 1'b1;
   localparam logic RST_PULL_UP  = 1'b1;
   localparam logic RST_ANALOG   = 1'b1;
   localparam logic RST_CFG_DONE = 1'b0;
endpackage : psc_pkg

//--- hw/psc_pad_if.sv
`timescale 1ns/1ps
interface psc_pad_if;
   logic oe;
   logic level;
   logic ie;
   logic pull_en;
   logic pull_up;
   modport ctrl (output oe, output level, output ie, output pull_en, output pull_up);
   modport pad  (input oe, input level, input ie, input pull_en, input pull_up);
endinterface : psc_pad_if

//--- hw/psc_pad_cell.sv
`timescale 1ns/1ps
// One pad: retention latch plus state-based override, registered outputs
module psc_pad_cell
   import psc_pkg::*;
(
   input  wire logic                sys_clk_i,
   input  wire logic                resetn_i,
   input  wire psc_pkg::psc_state_t state_i,
   input  wire logic                cfg_done_i,
   input  wire logic                retain_en_i,
   input  wire logic                por_pull_i,
   input  wire logic                default_ie_i,
   input  wire logic                analog_i,
   input  wire logic                fw_oe_i,
   input  wire logic                fw_level_i,
   input  wire logic                fw_pull_en_i,
   input  wire logic                fw_pull_up_i,
   psc_pad_if.ctrl                  pad
);
   logic ret_oe_q, ret_lvl_q, ret_pen_q, ret_pup_q;
   logic oe_d, lvl_d, pen_d, pup_d, ie_d;
   logic oe_q, lvl_q, pen_q, pup_q, ie_q;
   wire  sleeping = (state_i == PSC_DEEP_SLEEP) && retain_en_i;
   wire  active   = (state_i == PSC_PROC_ACTIVE) || (state_i == PSC_RADIO_ACTIVE) ||
                    ((state_i == PSC_DEEP_SLEEP) && !retain_en_i);

   always_comb
   begin
      oe_d  = 1'b0;
      lvl_d = 1'b0;
      pen_d = 1'b0;
      pup_d = 1'b0;
      ie_d  = 1'b0;
      if (analog_i)
      begin
         oe_d = 1'b0; // Analog wins over everything
      end
      else if (state_i == PSC_POR)
      begin
         pen_d = por_pull_i;
         pup_d = por_pull_i;
      end
      else if (state_i == PSC_DEFAULT || ((active || sleeping) && !cfg_done_i))
      begin
         ie_d  = default_ie_i;
         pen_d = default_ie_i;
         pup_d = default_ie_i;
      end
      else if (sleeping)
      begin
         oe_d  = ret_oe_q;
         lvl_d = ret_lvl_q;
         pen_d = ret_pen_q;
         pup_d = ret_pup_q;
         ie_d  = !ret_oe_q;
      end
      else if (active)
      begin
         oe_d  = fw_oe_i;
         lvl_d = fw_level_i;
         pen_d = fw_pull_en_i;
         pup_d = fw_pull_up_i;
         ie_d  = !fw_oe_i;
      end
   end

   // Capture while awake, freeze during sleep
   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         ret_oe_q  <= RST_OE;
         ret_lvl_q <= RST_LEVEL;
         ret_pen_q <= RST_PULL_EN;
         ret_pup_q <= RST_PULL_UP;
      end
      else if (!sleeping)
      begin
         ret_oe_q  <= fw_oe_i;
         ret_lvl_q <= fw_level_i;
         ret_pen_q <= fw_pull_en_i;
         ret_pup_q <= fw_pull_up_i;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         oe_q  <= 1'b0; // Core-off: all off
         lvl_q <= 1'b0;
         pen_q <= 1'b0;
         pup_q <= 1'b0;
         ie_q  <= 1'b0;
      end
      else
      begin
         oe_q  <= oe_d;
         lvl_q <= lvl_d;
         pen_q <= pen_d;
         pup_q <= pup_d;
         ie_q  <= ie_d;
      end
   end

   assign pad.oe      = oe_q;
   assign pad.level   = lvl_q;
   assign pad.ie      = ie_q;
   assign pad.pull_en = pen_q;
   assign pad.pull_up = pup_q;
endmodule : psc_pad_cell

//--- hw/psc_pad_state_ctrl.sv
// Overview of operation
// - Core off: every pad Hi-Z, input and pull disabled.
// - Power-on reset: all off; only wake pad pull-up enabled.
// - Unconfigured default: digital pads Hi-Z, input on, pull-up on.
// - Unconfigured default: mixed-signal pads input and pulls off.
// - Active states: oe, level, pull enable and direction follow firmware.
// - Firmware or retained: input enabled exactly when output disabled.
// - Deep sleep: switchable pads hold previous oe, level and pull.
// - Wake pad has no retention; behaves as in active states.
// - Mixed-signal analog select resets to analog, forcing everything off.
// - Analog mode overrides deep-sleep retention on mixed-signal pads.
// - No deep sleep while wake pin high; else on sleep request with no radio events pending.
`timescale 1ns/1ps
module psc_pad_state_ctrl
   import psc_pkg::*;
#(
   parameter int N_DIG = NUM_DIG,
   parameter int N_MIX = NUM_MIX
)(
   input  wire logic             sys_clk_i,
   input  wire logic             resetn_i,
   input  wire logic             core_enable_pin_i,
   input  wire logic             por_pulse_i,
   input  wire logic             radio_on_i,
   input  wire logic             sleep_req_i,
   input  wire logic             radio_events_pending_i,
   input  wire logic             cfg_done_i,
   input  wire logic [N_DIG-1:0] dig_oe_i,
   input  wire logic [N_DIG-1:0] dig_level_i,
   input  wire logic [N_DIG-1:0] dig_pull_en_i,
   input  wire logic [N_DIG-1:0] dig_pull_up_i,
   input  wire logic             wake_oe_i,
   input  wire logic             wake_level_i,
   input  wire logic             wake_pull_en_i,
   input  wire logic             wake_pull_up_i,
   input  wire logic [N_MIX-1:0] mix_oe_i,
   input  wire logic [N_MIX-1:0] mix_level_i,
   input  wire logic [N_MIX-1:0] mix_pull_en_i,
   input  wire logic [N_MIX-1:0] mix_pull_up_i,
   input  wire logic [N_MIX-1:0] mix_digital_i,
   input  wire logic             wake_pin_i,
   output logic      [2:0]       state_o,
   output logic      [N_DIG-1:0] dig_oe_o,
   output logic      [N_DIG-1:0] dig_level_o,
   output logic      [N_DIG-1:0] dig_ie_o,
   output logic      [N_DIG-1:0] dig_pull_en_o,
   output logic      [N_DIG-1:0] dig_pull_up_o,
   output logic                  wake_oe_o,
   output logic                  wake_level_o,
   output logic                  wake_ie_o,
   output logic                  wake_pull_en_o,
   output logic                  wake_pull_up_o,
   output logic      [N_MIX-1:0] mix_oe_o,
   output logic      [N_MIX-1:0] mix_level_o,
   output logic      [N_MIX-1:0] mix_ie_o,
   output logic      [N_MIX-1:0] mix_pull_en_o,
   output logic      [N_MIX-1:0] mix_pull_up_o
);
   import psc_pkg::*;

   psc_state_t       state_q, state_d;
   psc_state_t       run_st;
   logic             cfg_q, cfg_d;
   logic [N_MIX-1:0] analog_q, analog_d;

   // State decodes
   wire sleep_ok   = sleep_req_i && !wake_pin_i && !radio_events_pending_i;
   wire wake_exit  = wake_pin_i || !sleep_req_i || radio_events_pending_i;
   wire core_down  = (state_q == PSC_CORE_OFF) || (state_q == PSC_POR);
   wire enter_down = (state_d == PSC_CORE_OFF) || (state_d == PSC_POR);
   wire in_sleep   = (state_q == PSC_DEEP_SLEEP);
   assign run_st   = psc_state_t'(radio_on_i ? PSC_RADIO_ACTIVE : PSC_PROC_ACTIVE);

   // Power-state sequencer
   always_comb
   begin
      state_d = state_q;
      if (!core_enable_pin_i)
      begin
         state_d = PSC_CORE_OFF;
      end
      else if (por_pulse_i)
      begin
         state_d = PSC_POR;
      end
      else
      begin
         case (state_q)
            PSC_CORE_OFF:     state_d = PSC_POR;
            PSC_POR:          state_d = PSC_DEFAULT;
            PSC_DEFAULT:      state_d = psc_state_t'(cfg_q ? run_st : PSC_DEFAULT);
            PSC_PROC_ACTIVE,
            PSC_RADIO_ACTIVE: state_d = psc_state_t'(sleep_ok ? PSC_DEEP_SLEEP : run_st);
            PSC_DEEP_SLEEP:   state_d = psc_state_t'(wake_exit ? run_st : PSC_DEEP_SLEEP);
            default:          state_d = PSC_CORE_OFF;
         endcase
      end
   end

   // Sticky configuration flag, cleared on the way down
   assign cfg_d = enter_down ? RST_CFG_DONE : (cfg_q || cfg_done_i);

   // Analog select: reset to analog, frozen in sleep
   always_comb
   begin
      analog_d = ~mix_digital_i;
      if (core_down)
      begin
         analog_d = {N_MIX{RST_ANALOG}};
      end
      else if (in_sleep)
      begin
         analog_d = analog_q;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         state_q  <= PSC_CORE_OFF;
         cfg_q    <= RST_CFG_DONE;
         analog_q <= {N_MIX{RST_ANALOG}};
      end
      else
      begin
         state_q  <= state_d;
         cfg_q    <= cfg_d;
         analog_q <= analog_d;
      end
   end

   assign state_o = 3'(state_q);

   // Per pad-type ties
   localparam logic DIG_RETAIN  = 1'b1;
   localparam logic WAKE_RETAIN = 1'b0;
   localparam logic WAKE_POR_PU = 1'b1;
   localparam logic DIG_DFLT_IE = 1'b1;
   localparam logic MIX_DFLT_IE = 1'b0;

   genvar g;
   generate
      // Switchable-domain digital pads
      for (g = 0; g < N_DIG; g++)
      begin : g_dig
         psc_pad_if p ();
         psc_pad_cell u_cell (
            .sys_clk_i    (sys_clk_i),
            .resetn_i     (resetn_i),
            .state_i      (state_q),
            .cfg_done_i   (cfg_q),
            .retain_en_i  (DIG_RETAIN),
            .por_pull_i   (1'b0),
            .default_ie_i (DIG_DFLT_IE),
            .analog_i     (1'b0),
            .fw_oe_i      (dig_oe_i[g]),
            .fw_level_i   (dig_level_i[g]),
            .fw_pull_en_i (dig_pull_en_i[g]),
            .fw_pull_up_i (dig_pull_up_i[g]),
            .pad          (p.ctrl)
         );
         assign dig_oe_o[g]      = p.oe;
         assign dig_level_o[g]   = p.level;
         assign dig_ie_o[g]      = p.ie;
         assign dig_pull_en_o[g] = p.pull_en;
         assign dig_pull_up_o[g] = p.pull_up;
      end

      // Mixed-signal pads, analog select first
      for (g = 0; g < N_MIX; g++)
      begin : g_mix
         psc_pad_if p ();
         psc_pad_cell u_cell (
            .sys_clk_i    (sys_clk_i),
            .resetn_i     (resetn_i),
            .state_i      (state_q),
            .cfg_done_i   (cfg_q),
            .retain_en_i  (DIG_RETAIN),
            .por_pull_i   (1'b0),
            .default_ie_i (MIX_DFLT_IE),
            .analog_i     (analog_q[g]),
            .fw_oe_i      (mix_oe_i[g]),
            .fw_level_i   (mix_level_i[g]),
            .fw_pull_en_i (mix_pull_en_i[g]),
            .fw_pull_up_i (mix_pull_up_i[g]),
            .pad          (p.ctrl)
         );
         assign mix_oe_o[g]      = p.oe;
         assign mix_level_o[g]   = p.level;
         assign mix_ie_o[g]      = p.ie;
         assign mix_pull_en_o[g] = p.pull_en;
         assign mix_pull_up_o[g] = p.pull_up;
      end
   endgenerate

   // Wake pad: no retention, pull-up during power-on reset
   psc_pad_if wk ();
   psc_pad_cell u_wake (
      .sys_clk_i    (sys_clk_i),
      .resetn_i     (resetn_i),
      .state_i      (state_q),
      .cfg_done_i   (cfg_q),
      .retain_en_i  (WAKE_RETAIN),
      .por_pull_i   (WAKE_POR_PU),
      .default_ie_i (DIG_DFLT_IE),
      .analog_i     (1'b0),
      .fw_oe_i      (wake_oe_i),
      .fw_level_i   (wake_level_i),
      .fw_pull_en_i (wake_pull_en_i),
      .fw_pull_up_i (wake_pull_up_i),
      .pad          (wk.ctrl)
   );
   assign wake_oe_o      = wk.oe;
   assign wake_level_o   = wk.level;
   assign wake_ie_o      = wk.ie;
   assign wake_pull_en_o = wk.pull_en;
   assign wake_pull_up_o = wk.pull_up;
endmodule : psc_pad_state_ctrl

//--- testbench/psc_sva.sv
`timescale 1ns/1ps
module psc_sva
   import psc_pkg::*;
#(
   parameter int N_DIG = NUM_DIG,
   parameter int N_MIX = NUM_MIX
)(
   input  wire logic             sys_clk_i,
   input  wire logic             resetn_i,
   input  wire logic             core_enable_pin_i,
   input  wire logic             wake_pin_i,
   input  wire logic [N_MIX-1:0] mix_digital_i,
   input  wire logic [2:0]       state_o,
   input  wire logic [N_DIG-1:0] dig_oe_o,
   input  wire logic [N_DIG-1:0] dig_level_o,
   input  wire logic [N_DIG-1:0] dig_ie_o,
   input  wire logic [N_DIG-1:0] dig_pull_en_o,
   input  wire logic [N_DIG-1:0] dig_pull_up_o,
   input  wire logic             wake_oe_o,
   input  wire logic             wake_ie_o,
   input  wire logic             wake_pull_en_o,
   input  wire logic             wake_pull_up_o,
   input  wire logic [N_MIX-1:0] mix_oe_o,
   input  wire logic [N_MIX-1:0] mix_ie_o,
   input  wire logic [N_MIX-1:0] mix_pull_en_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);
   core_off_a: assert property (state_o == PSC_CORE_OFF |=> !(|{dig_oe_o, dig_ie_o,
      dig_pull_en_o, wake_oe_o, wake_ie_o, wake_pull_en_o, mix_oe_o, mix_ie_o, mix_pull_en_o}))
      else $error("pad active in core off");
   por_pads_a: assert property (state_o == PSC_POR |=> wake_pull_en_o && wake_pull_up_o
      && !(|{wake_ie_o, dig_oe_o, dig_ie_o, dig_pull_en_o, mix_ie_o, mix_pull_en_o}))
      else $error("wrong pads in power-on reset");
   dflt_dig_a: assert property (state_o == PSC_DEFAULT |=> !(|dig_oe_o)
      && (&{dig_ie_o, dig_pull_en_o, dig_pull_up_o}))
      else $error("digital pads not at default");
   dflt_mix_a: assert property (state_o == PSC_DEFAULT |=>
      !(|{mix_oe_o, mix_ie_o, mix_pull_en_o}))
      else $error("mixed pads not off at default");
   pad_dir_a: assert property (state_o >= PSC_PROC_ACTIVE |=>
      dig_ie_o == ~dig_oe_o && wake_ie_o != wake_oe_o)
      else $error("input enable not opposite of output");
   sleep_hold_a: assert property (state_o == PSC_DEEP_SLEEP
      && $past(state_o) == PSC_DEEP_SLEEP |=>
      $stable({dig_oe_o, dig_level_o, dig_pull_en_o, dig_pull_up_o}))
      else $error("retained pad changed in sleep");
   analog_off_a: assert property ((state_o inside {PSC_PROC_ACTIVE, PSC_RADIO_ACTIVE}
      && mix_digital_i == '0) [*3] |=> !(|{mix_oe_o, mix_ie_o, mix_pull_en_o}))
      else $error("analog pad not off");
   sleep_block_a: assert property (wake_pin_i && state_o != PSC_DEEP_SLEEP |=>
      state_o != PSC_DEEP_SLEEP)
      else $error("sleep entered with wake pin high");
   core_en_a: assert property (!core_enable_pin_i |=> state_o == PSC_CORE_OFF)
      else $error("core enable low but not core off");
endmodule : psc_sva

//--- testbench/psc_pad_partner.sv
`timescale 1ns/1ps
// Far-side lines: driven, pulled, or drifting when floating
module psc_pad_partner (
   input  wire logic        sys_clk_i,
   input  wire logic [22:0] oe_i,
   input  wire logic [22:0] level_i,
   input  wire logic [22:0] pull_en_i,
   input  wire logic [22:0] pull_up_i,
   output logic      [22:0] pad_o
);
   logic [22:0] last_q = '0;
   assign pad_o = (oe_i & level_i) | (~oe_i & pull_en_i & pull_up_i)
                  | (~oe_i & ~pull_en_i & ~last_q);
   always_ff @(posedge sys_clk_i) last_q <= pad_o;
endmodule : psc_pad_partner

//--- testbench/psc_pad_state_ctrl_tb.sv
`timescale 1ns/1ps
module psc_pad_state_ctrl_tb;
   import psc_pkg::*;
   logic sys_clk_i = 0, resetn_i = 0, core_enable_pin_i = 0, por_pulse_i = 0, radio_on_i = 0;
   logic sleep_req_i = 0, radio_events_pending_i = 0, cfg_done_i = 0, wake_pin_i = 0;
   logic wake_oe_i = 0, wake_level_i = 0, wake_pull_en_i = 0, wake_pull_up_i = 0;
   logic [22:0] dig_oe_i = 0, dig_level_i = 0, dig_pull_en_i = 0, dig_pull_up_i = 0;
   logic [3:0]  mix_oe_i = 0, mix_level_i = 0, mix_pull_en_i = 0, mix_pull_up_i = 0;
   logic [3:0]  mix_digital_i = 0, rm_oe, rm_lv, rm_pe, rm_pu;
   logic [22:0] r_oe, r_lv, r_pe, r_pu, pad_lvl;
   logic [2:0]  state_o;
   logic [22:0] dig_oe_o, dig_level_o, dig_ie_o, dig_pull_en_o, dig_pull_up_o;
   logic        wake_oe_o, wake_level_o, wake_ie_o, wake_pull_en_o, wake_pull_up_o;
   logic [3:0]  mix_oe_o, mix_level_o, mix_ie_o, mix_pull_en_o, mix_pull_up_o;
   int          n_mismatch = 0, checked = 0;
   psc_pad_state_ctrl DUT (.sys_clk_i, .resetn_i, .core_enable_pin_i, .por_pulse_i, .radio_on_i,
      .sleep_req_i, .radio_events_pending_i, .cfg_done_i, .dig_oe_i, .dig_level_i, .dig_pull_en_i,
      .dig_pull_up_i, .wake_oe_i, .wake_level_i, .wake_pull_en_i, .wake_pull_up_i, .mix_oe_i,
      .mix_level_i, .mix_pull_en_i, .mix_pull_up_i, .mix_digital_i, .wake_pin_i, .state_o,
      .dig_oe_o, .dig_level_o, .dig_ie_o, .dig_pull_en_o, .dig_pull_up_o, .wake_oe_o,
      .wake_level_o, .wake_ie_o, .wake_pull_en_o, .wake_pull_up_o, .mix_oe_o, .mix_level_o,
      .mix_ie_o, .mix_pull_en_o, .mix_pull_up_o);
   psc_pad_partner u_far (.sys_clk_i, .oe_i(dig_oe_o), .level_i(dig_level_o),
      .pull_en_i(dig_pull_en_o), .pull_up_i(dig_pull_up_o), .pad_o(pad_lvl));
   initial
   begin
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   // Level and pull direction only matter when driven or pulled
   function automatic logic [114:0] f(logic [22:0] oe, lv, ie, pe, pu);
      return {oe, lv & oe, ie, pe, pu & pe};
   endfunction : f
   function automatic logic [344:0] got();
      return {f(dig_oe_o, dig_level_o, dig_ie_o, dig_pull_en_o, dig_pull_up_o),
         f(wake_oe_o, wake_level_o, wake_ie_o, wake_pull_en_o, wake_pull_up_o),
         f(mix_oe_o, mix_level_o, mix_ie_o, mix_pull_en_o, mix_pull_up_o)};
   endfunction : got
   function automatic logic [344:0] model(int s);
      logic [114:0] wk;
      wk = f(wake_oe_i, wake_level_i, !wake_oe_i, wake_pull_en_i, wake_pull_up_i);
      case (s)
         0: return '0;
         1: return {f('0, '0, '0, '0, '0), f('0, '0, '0, 23'h1, 23'h1), f('0, '0, '0, '0, '0)};
         2: return {f('0, '0, '1, '1, '1), f('0, '0, 23'h1, 23'h1, 23'h1), f('0, '0, '0, '0, '0)};
         5: return {f(r_oe, r_lv, ~r_oe, r_pe, r_pu), wk, f(rm_oe & mix_digital_i, rm_lv,
            ~rm_oe & mix_digital_i, rm_pe & mix_digital_i, rm_pu)};
         default: return {f(dig_oe_i, dig_level_i, ~dig_oe_i, dig_pull_en_i, dig_pull_up_i), wk,
            f(mix_oe_i & mix_digital_i, mix_level_i, ~mix_oe_i & mix_digital_i,
            mix_pull_en_i & mix_digital_i, mix_pull_up_i)};
      endcase
   endfunction : model
   task automatic print_verdict();
      $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input bit ok);
      checked++;
      if (!ok)
      begin
         n_mismatch++;
         $display("[FAIL] %0t pads differ, state %0d", $time, state_o);
      end
   endtask : chk
   task automatic wait_st(input logic [2:0] s);
      for (int i = 0; i < 40 && state_o !== s; i++)
         @(negedge sys_clk_i);
      chk(state_o === s);
      if (state_o !== s)
         print_verdict();
      repeat (4) @(negedge sys_clk_i);
   endtask : wait_st
   task automatic rnd();
      {dig_oe_i, dig_level_i, dig_pull_en_i, dig_pull_up_i} = 92'({$urandom, $urandom, $urandom});
      {wake_oe_i, wake_level_i, wake_pull_en_i, wake_pull_up_i, mix_oe_i, mix_level_i,
         mix_pull_en_i, mix_pull_up_i} = 20'($urandom);
   endtask : rnd
   initial
   begin
      void'($urandom(32'hb1d2ec2b));
      repeat (12) @(negedge sys_clk_i);
      resetn_i = 1;
      chk(got() === model(0));
      core_enable_pin_i = 1;
      por_pulse_i = 1;
      wait_st(PSC_POR);
      chk(got() === model(1));
      por_pulse_i = 0;
      rnd();
      wait_st(PSC_DEFAULT);
      chk(got() === model(2));
      chk(pad_lvl === '1);
      cfg_done_i = 1;
      for (int i = 0; i < 6; i++)
      begin
         rnd();
         {radio_on_i, mix_digital_i} = 5'($urandom);
         if (i < 2)
            {radio_on_i, mix_digital_i} = {i[0], 4'h0};
         wait_st(radio_on_i ? PSC_RADIO_ACTIVE : PSC_PROC_ACTIVE);
         chk(got() === model(3));
         chk((pad_lvl & (dig_oe_i | dig_pull_en_i)) === ((dig_oe_i & dig_level_i)
            | (~dig_oe_i & dig_pull_en_i & dig_pull_up_i)));
      end
      mix_digital_i = 4'h5;
      wake_pin_i = 1;
      sleep_req_i = 1;
      repeat (6) @(negedge sys_clk_i);
      chk(state_o !== PSC_DEEP_SLEEP);
      wake_pin_i = 0;
      radio_events_pending_i = 1;
      repeat (6) @(negedge sys_clk_i);
      chk(state_o !== PSC_DEEP_SLEEP);
      {r_oe, r_lv, r_pe, r_pu} = {dig_oe_i, dig_level_i, dig_pull_en_i, dig_pull_up_i};
      {rm_oe, rm_lv, rm_pe, rm_pu} = {mix_oe_i, mix_level_i, mix_pull_en_i, mix_pull_up_i};
      radio_events_pending_i = 0;
      wait_st(PSC_DEEP_SLEEP);
      rnd();
      repeat (4) @(negedge sys_clk_i);
      chk(got() === model(5));
      wake_pin_i = 1;
      sleep_req_i = 0;
      repeat (6) @(negedge sys_clk_i);
      chk(state_o !== PSC_DEEP_SLEEP);
      core_enable_pin_i = 0;
      wait_st(PSC_CORE_OFF);
      chk(got() === model(0));
      print_verdict();
   end
endmodule : psc_pad_state_ctrl_tb
bind psc_pad_state_ctrl psc_sva #(.N_DIG(N_DIG), .N_MIX(N_MIX)) u_sva (.sys_clk_i, .resetn_i,
   .core_enable_pin_i, .wake_pin_i, .mix_digital_i, .state_o, .dig_oe_o, .dig_level_o, .dig_ie_o,
   .dig_pull_en_o, .dig_pull_up_o, .wake_oe_o, .wake_ie_o, .wake_pull_en_o, .wake_pull_up_o,
   .mix_oe_o, .mix_ie_o, .mix_pull_en_o);
